/* File: src/srcc_pkg.sv */
// Package with register map, field positions and carrier types.
package srcc_pkg;
    localparam logic [7:0] SRCC_ADDR_PATH_CTRL = 8'h29;
    localparam logic [7:0] SRCC_ADDR_INPUT_OPT = 8'h2a;
    localparam logic [7:0] SRCC_RESET_VALUE = 8'h00;
    localparam logic [7:0] SRCC_READ_UNMAPPED = 8'h00;
    localparam int SRCC_POS_WIDTH = 24;
    localparam int SRCC_SAMPLE_WIDTH = 16;
    localparam int SRCC_DECIM_WIDTH = 6;
    localparam logic [5:0] SRCC_DECIM_BYPASS = 6'h01;
    localparam int SRCC_NUM_REGS = 2;

    typedef struct packed {
        logic reserved;
        logic align_event_processor_enable;
        logic align_receiver_enable;
        logic window_fine_scale;
        logic [3:0] capture_delay_select;
    } srcc_path_control_t;

    typedef struct packed {
        logic [3:0] reserved;
        logic align_timestamp_enable;
        logic device_clock_dc_coupled_mode;
        logic align_input_dc_coupled_mode;
        logic align_polarity_invert;
    } srcc_input_options_t;

    typedef struct packed {
        logic write_strobe;
        logic read_strobe;
        logic [7:0] addr;
        logic [7:0] wdata;
    } srcc_access_t;
endpackage

/* File: src/srcc_reg_store.sv */
// Small register store holding the configuration bytes with registered read.
`timescale 1ns/1ns
module srcc_reg_store (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Write port.
    input wire logic wr_en,
    input wire logic [0:0] wr_index,
    input wire logic [7:0] wr_data,
    // Read port.
    input wire logic [0:0] rd_index,
    output logic [7:0] rd_data,
    // Full contents for the datapath.
    output logic [15:0] contents
);
    import srcc_pkg::*;

    logic [7:0] mem_reg [SRCC_NUM_REGS];
    logic [7:0] mem_next [SRCC_NUM_REGS];
    logic [7:0] rd_data_next;

    always_comb begin
        for (int i = 0; i < SRCC_NUM_REGS; i++) begin
            mem_next[i] = mem_reg[i];
        end
        if (wr_en) begin
            mem_next[wr_index] = wr_data;
        end
        rd_data_next = mem_reg[rd_index];
    end

    always_ff @(posedge clk) begin
        for (int i = 0; i < SRCC_NUM_REGS; i++) begin
            if (reset) begin
                mem_reg[i] <= SRCC_RESET_VALUE;
            end else begin
                mem_reg[i] <= mem_next[i];
            end
        end
        if (reset) begin
            rd_data <= SRCC_RESET_VALUE;
        end else begin
            rd_data <= rd_data_next;
        end
    end

    assign contents = {mem_reg[1], mem_reg[0]};
endmodule // srcc_reg_store

/* File: src/srcc_regs.sv */
// Alignment-signal and clock input control register bank with its datapath.
`timescale 1ns/1ns
// Summary of operation
// - Alignment events are processed only while the processor enable bit is set.
// - Receiver is powered and enabled exactly while its enable bit is set.
// - Fine scale bit selects smaller windowing delay steps.
// - The four-bit capture delay code selects the applied capture delay.
// - Timestamp plus sample marker puts alignment signal on sample LSB.
// - Timestamp on samples works only with decimation factor one.
// - Clock dc-coupled bit selects DC-coupled PECL clock input mode.
// - Alignment dc-coupled bit selects DC-coupled PECL alignment input mode.
// - Polarity invert bit inverts the alignment signal before use.
// - First control register resets to all zeros.
// - Second control register resets to all zeros.
// - A 24-bit edge position status is reported for the host.
module srcc_regs (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Control port access.
    input wire srcc_pkg::srcc_access_t access,
    output logic [7:0] read_data,
    output logic read_valid,
    // Alignment signal and windowing detector.
    input wire logic align_in,
    input wire logic [23:0] edge_detector_raw,
    output logic [23:0] edge_position_status,
    // Sample path.
    input wire logic sample_marker_enable,
    input wire logic [5:0] decimation_factor,
    input wire logic [15:0] sample_in,
    output logic [15:0] sample_out,
    // Analog control outputs.
    output logic receiver_power_enable,
    output logic align_event,
    output logic window_fine_step,
    output logic [3:0] capture_delay_code,
    output logic clock_input_dc_mode,
    output logic align_input_dc_mode
);
    import srcc_pkg::*;

    srcc_path_control_t path_ctrl;
    srcc_input_options_t in_opts;
    logic [15:0] contents;
    logic [7:0] store_rd;
    logic wr_hit;
    logic rd_hit_reg;
    logic rd_hit_next;
    logic [23:0] pos_reg;
    logic [23:0] pos_next;
    logic [15:0] sample_reg;
    logic [15:0] sample_next;
    logic align_reg;
    logic align_next;
    logic align_prev_reg;
    logic event_reg;
    logic event_next;

    function automatic logic is_mapped(input logic [7:0] a);
        return (a == SRCC_ADDR_PATH_CTRL) || (a == SRCC_ADDR_INPUT_OPT);
    endfunction

    assign wr_hit = access.write_strobe && is_mapped(access.addr);

    srcc_reg_store u_store (
        .clk(clk),
        .reset(reset),
        .wr_en(wr_hit),
        .wr_index(access.addr == SRCC_ADDR_INPUT_OPT),
        .wr_data(access.wdata),
        .rd_index(access.addr == SRCC_ADDR_INPUT_OPT),
        .rd_data(store_rd),
        .contents(contents)
    );

    assign path_ctrl = srcc_path_control_t'(contents[7:0]);
    assign in_opts = srcc_input_options_t'(contents[15:8]);

    always_comb begin
        rd_hit_next = access.read_strobe && is_mapped(access.addr);
        // Alignment level, inverted when the polarity invert bit is set, gated by the receiver enable.
        align_next = path_ctrl.align_receiver_enable
            && (align_in ^ in_opts.align_polarity_invert);
        // Rising edge counts as an event only with the processor enabled.
        event_next = path_ctrl.align_event_processor_enable
            && align_reg && !align_prev_reg;
        pos_next = path_ctrl.align_receiver_enable
            ? edge_detector_raw : pos_reg;
        sample_next = sample_in;
        if (in_opts.align_timestamp_enable && sample_marker_enable
            && decimation_factor == SRCC_DECIM_BYPASS) begin
            sample_next[0] = align_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rd_hit_reg <= 1'b0;
            align_reg <= 1'b0;
            align_prev_reg <= 1'b0;
            event_reg <= 1'b0;
            pos_reg <= '0;
            sample_reg <= '0;
        end else begin
            rd_hit_reg <= rd_hit_next;
            align_reg <= align_next;
            align_prev_reg <= align_reg;
            event_reg <= event_next;
            pos_reg <= pos_next;
            sample_reg <= sample_next;
        end
    end

    assign read_valid = rd_hit_reg;
    assign read_data = rd_hit_reg ? store_rd : SRCC_READ_UNMAPPED;
    assign edge_position_status = pos_reg;
    assign sample_out = sample_reg;
    assign align_event = event_reg;
    assign receiver_power_enable = path_ctrl.align_receiver_enable;
    assign window_fine_step = path_ctrl.window_fine_scale;
    assign capture_delay_code = path_ctrl.capture_delay_select;
    assign clock_input_dc_mode = in_opts.device_clock_dc_coupled_mode;
    assign align_input_dc_mode = in_opts.align_input_dc_coupled_mode;

    property write_then_read(logic [7:0] a);
        @(posedge clk) disable iff (reset)
        (access.write_strobe && access.addr == a) ##1
        (access.read_strobe && access.addr == a && !access.write_strobe)
        |=> read_data == $past(access.wdata, 2);
    endproperty
    sequence rise_seen;
        align_reg && !align_prev_reg;
    endsequence

    reset_zero_a: assert property (@(posedge clk) $past(reset) |-> contents == '0) else $error("registers not zero after reset");
    readback_path_a: assert property (write_then_read(SRCC_ADDR_PATH_CTRL)) else $error("path control readback wrong");
    readback_opts_a: assert property (write_then_read(SRCC_ADDR_INPUT_OPT)) else $error("input options readback wrong");
    event_gate_a: assert property (@(posedge clk) disable iff (reset) align_event |-> $past(path_ctrl.align_event_processor_enable)) else $error("event while processor off");
    event_pass_a: assert property (@(posedge clk) disable iff (reset) (rise_seen and path_ctrl.align_event_processor_enable) |=> align_event) else $error("event lost");
    receiver_off_a: assert property (@(posedge clk) disable iff (reset) !path_ctrl.align_receiver_enable |=> !align_reg) else $error("receiver off but active");
    invert_path_a: assert property (@(posedge clk) disable iff (reset) path_ctrl.align_receiver_enable |=> align_reg == ($past(align_in) ^ $past(in_opts.align_polarity_invert))) else $error("polarity wrong");
    stamp_bypass_a: assert property (@(posedge clk) disable iff (reset) decimation_factor != SRCC_DECIM_BYPASS |=> sample_out == $past(sample_in)) else $error("stamp outside bypass");
    delay_code_a: assert property (@(posedge clk) disable iff (reset) capture_delay_code == contents[3:0] && window_fine_step == contents[4]) else $error("delay controls wrong");
    dc_modes_a: assert property (@(posedge clk) disable iff (reset) clock_input_dc_mode == contents[10] && align_input_dc_mode == contents[9]) else $error("dc mode wrong");
    pos_hold_a: assert property (@(posedge clk) disable iff (reset) !path_ctrl.align_receiver_enable |=> $stable(edge_position_status)) else $error("position changed while off");
endmodule // srcc_regs

/* File: verification/srcc_align_src.sv */
// Far-side model driving the alignment level, detector value and samples.
`timescale 1ns/1ns
module srcc_align_src (
    // Clock and level request.
    input wire logic clk,
    input wire logic level_req,
    // Far-side signals.
    output logic align_in,
    output logic [23:0] edge_detector_raw,
    output logic [15:0] sample_in
);
    logic [23:0] ramp_reg = 24'h5a5a5a;
    assign align_in = level_req;
    assign edge_detector_raw = ramp_reg;
    assign sample_in = ramp_reg[19:4];
    // The ramp changes every cycle so a stale capture cannot pass.
    always @(posedge clk) begin
        ramp_reg <= ramp_reg + 24'h0b0a09;
    end
endmodule // srcc_align_src

/* File: verification/tb.sv */
// Self-checking bench for the alignment control register bank.
`timescale 1ns/1ns
module tb;
    import srcc_pkg::*;
    logic clk = 0, reset = 1, lvl = 0, marker = 0;
    logic [5:0] decim = 6'h01;
    srcc_access_t acc = '0;
    logic [7:0] read_data, d0, d1;
    logic read_valid, align_in, align_event, rpe, wfs, cdm, adm;
    logic [23:0] raw, pos, r_hist, snap;
    logic [15:0] s_in, s_out, s_hist;
    logic [3:0] cdc;
    logic [7:0] exp_q[$];
    int err_total = 0, num_checks = 0, cycles = 0, i;
    int seed = 32'h3004fc77;
    always #50 clk = ~clk;
    srcc_align_src far (.clk(clk), .level_req(lvl), .align_in(align_in),
        .edge_detector_raw(raw), .sample_in(s_in));
    srcc_regs dut (.clk(clk), .reset(reset), .access(acc),
        .read_data(read_data), .read_valid(read_valid),
        .align_in(align_in), .edge_detector_raw(raw),
        .edge_position_status(pos), .sample_marker_enable(marker),
        .decimation_factor(decim), .sample_in(s_in), .sample_out(s_out),
        .receiver_power_enable(rpe), .align_event(align_event),
        .window_fine_step(wfs), .capture_delay_code(cdc),
        .clock_input_dc_mode(cdm), .align_input_dc_mode(adm));
    task give_verdict;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) acc <= {1'b1, 1'b0, a, d};
        @(posedge clk) acc <= '0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e, input logic v);
        @(posedge clk) acc <= {1'b0, 1'b1, a, 8'h00};
        if (v) exp_q.push_back(e);
        @(posedge clk) acc <= '0;
        repeat (2) @(posedge clk);
    endtask
    task pulse(input logic l, input logic e);
        @(posedge clk) lvl <= l;
        repeat (2) @(posedge clk);
        @(negedge clk) chk(align_event, e);
        @(negedge clk) chk(align_event, 0);
    endtask
    task samp(input logic e, input logic use_e);
        repeat (3) @(posedge clk);
        @(negedge clk) chk(s_out, {s_hist[15:1], use_e ? e : s_hist[0]});
    endtask
    // Read results are compared in issue order as they appear.
    always @(negedge clk) if (read_valid === 1'b1) begin
        if (exp_q.size() == 0) chk(read_valid, 0);
        else chk(read_data, exp_q.pop_front());
    end
    always @(posedge clk) begin
        s_hist <= s_in;
        r_hist <= raw;
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            give_verdict;
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        reset <= 0;
        rd(SRCC_ADDR_PATH_CTRL, 8'h00, 1);
        rd(SRCC_ADDR_INPUT_OPT, 8'h00, 1);
        for (i = 0; i < 8; i++) begin
            d0 = $random(seed);
            d1 = $random(seed);
            wr(SRCC_ADDR_PATH_CTRL, d0);
            wr(SRCC_ADDR_INPUT_OPT, d1);
            rd(SRCC_ADDR_PATH_CTRL, d0, 1);
            rd(SRCC_ADDR_INPUT_OPT, d1, 1);
            chk({rpe, wfs, cdc, cdm, adm}, {d0[5:0], d1[2:1]});
        end
        rd(8'h2b, 8'h00, 0);
        wr(SRCC_ADDR_INPUT_OPT, 8'h00);
        wr(SRCC_ADDR_PATH_CTRL, 8'h20);
        wr(SRCC_ADDR_PATH_CTRL, 8'h60);
        pulse(1, 1);
        pulse(0, 0);
        wr(SRCC_ADDR_INPUT_OPT, 8'h01);
        pulse(1, 0);
        pulse(0, 1);
        wr(SRCC_ADDR_PATH_CTRL, 8'h20);
        pulse(1, 0);
        pulse(0, 0);
        @(negedge clk) chk(pos, r_hist);
        wr(SRCC_ADDR_INPUT_OPT, 8'h08);
        marker <= 1;
        samp(0, 1);
        wr(SRCC_ADDR_INPUT_OPT, 8'h09);
        samp(1, 1);
        decim <= 6'h02;
        samp(0, 0);
        decim <= SRCC_DECIM_BYPASS;
        marker <= 0;
        samp(0, 0);
        wr(SRCC_ADDR_PATH_CTRL, 8'h00);
        repeat (2) @(posedge clk);
        snap = pos;
        repeat (3) @(negedge clk);
        chk(pos, snap);
        give_verdict;
    end
endmodule // tb
